// *** hdl/pmicc_pkg.sv ***
// Shared constants for the charger control register block.
// Assumes a 100 MHz system clock and byte-wide registers over I2C.
package pmicc_pkg;

	// ==========================================
	// Clock and time base
	localparam int CLK_PERIOD_NS       = 10;
	localparam int SECOND_NS           = 1000000000;
	localparam int SECOND_CYCLES       = SECOND_NS / CLK_PERIOD_NS;
	localparam int WATCHDOG_PERIOD_MS  = 1000;
	localparam int WATCHDOG_CYCLES     = WATCHDOG_PERIOD_MS * (1000000 / CLK_PERIOD_NS);

	// ==========================================
	// Register offsets
	localparam logic [7:0] ADDR_POWER_KEY = 8'h0c;
	localparam logic [7:0] ADDR_WD_KICK   = 8'h0d;
	localparam logic [7:0] ADDR_CHG_CTL   = 8'h10;
	localparam logic [7:0] ADDR_FCC       = 8'h11;

	// ==========================================
	// Field positions
	localparam int KEY_LSB     = 3;
	localparam int THERM_BIT   = 2;
	localparam int TIMER_BIT   = 1;
	localparam int CHARGER_ENABLE_BIT  = 0;

	// ==========================================
	// Reset values and codes
	localparam logic [1:0] LONG_PRESS_RST    = 2'h1;
	localparam logic [4:0] KEY_RST           = 5'h00;
	localparam logic [4:0] KEY_UNLOCK        = 5'h15;
	localparam logic       THERM_RST         = 1'h0;
	localparam logic       TIMER_RST         = 1'h1;
	localparam logic       CHARGER_ENABLE_RST        = 1'h1;
	localparam logic [5:0] FCC_RST           = 6'h08;
	localparam logic [2:0] KICK_CODE         = 3'h1;
	localparam logic [4:0] LONG_PRESS_STEP_S = 5'h04;
	localparam logic [2:0] CURRENT_STEP_MA   = 3'h5;
	localparam logic [6:0] DEVICE_ADDRESS    = 7'h2a; // Arbitrary default

	// ==========================================
	// I2C slave states
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} pmicc_state_t;

endpackage

// *** hdl/pmicc_watchdog.sv ***
// Watchdog counter restarted by a one-cycle kick pulse.
// Assumes the kick comes from logic on the same clock.
`timescale 1ns/100ps
module pmicc_watchdog
	import pmicc_pkg::*;
#(
	parameter int PERIOD_CYCLES = WATCHDOG_CYCLES
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// Control
	input  wire logic kick_in,
	// Status
	output logic      expired_out
);

	logic [31:0] count_reg;
	logic        expired_reg;

	// ==========================================
	// Count, restart on kick only
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			count_reg <= 32'h0;
		end else if (kick_in) begin
			count_reg <= 32'h0;
		end else if (count_reg != 32'(PERIOD_CYCLES - 1)) begin
			count_reg <= count_reg + 32'h1;
		end
	end

	// Expiry stays up until the next kick
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			expired_reg <= 1'b0;
		end else if (kick_in) begin
			expired_reg <= 1'b0;
		end else if (count_reg == 32'(PERIOD_CYCLES - 1)) begin
			expired_reg <= 1'b1;
		end
	end

	assign expired_out = expired_reg;

endmodule

// *** hdl/pmicc_top.sv ***
// Charger control registers behind an I2C slave port, with watchdog
// kick, write-key protection and power key long press timing.
// Assumes SCL and SDA arrive asynchronously and SDA is open drain.
`timescale 1ns/100ps
module pmicc_top
	import pmicc_pkg::*;
#(
	parameter int KEY_SECOND_CYCLES = SECOND_CYCLES,
	parameter int WD_CYCLES         = WATCHDOG_CYCLES
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	// I2C pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	// Board inputs
	input  wire logic       power_key_n_in,
	input  wire logic       thermistor_sense_pin_in,
	// Charger controls
	output logic            charger_enable_out,
	output logic            charge_safety_timer_enable_out,
	output logic            thermistor_control_enable_out,
	output logic            thermistor_sense_active_out,
	output logic [5:0]      fast_charge_current_code_out,
	output logic [8:0]      fast_charge_current_ma_out,
	// Status
	output logic            power_key_long_press_out,
	output logic            watchdog_expired_out
);

	// ==========================================
	// Register storage
	logic [1:0] power_key_long_press_time_reg;
	logic [4:0] charger_write_key_reg;
	logic       thermistor_control_enable_reg;
	logic       charge_safety_timer_enable_reg;
	logic       charger_enable_reg;
	logic [5:0] fast_charge_current_code_reg;
	logic [8:0] fast_charge_current_ma_reg;
	logic       watchdog_kick_reg;

	// Read view of each offset; 0Dh and unmapped offsets read zero
	function automatic logic [7:0] read_byte(input logic [7:0] addr);
		logic [7:0] data;
		data = 8'h00;
		case (addr)
			ADDR_POWER_KEY: data = {6'h00, power_key_long_press_time_reg};
			ADDR_CHG_CTL:   data = {charger_write_key_reg, thermistor_control_enable_reg,
				charge_safety_timer_enable_reg, charger_enable_reg};
			ADDR_FCC:       data = {2'h0, fast_charge_current_code_reg};
			default:        data = 8'h00;
		endcase
		return data;
	endfunction

	// A function result cannot be bit-selected, so the read view is a net
	logic [7:0] rd_byte;
	assign rd_byte = read_byte(ptr_reg);

	// ==========================================
	// Pin synchronisers
	logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
	logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
	logic key_meta_reg, key_sync_reg;
	logic ts_meta_reg,  ts_sync_reg;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			scl_meta_reg <= 1'b1;
			scl_sync_reg <= 1'b1;
			scl_prev_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			sda_sync_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			key_meta_reg <= 1'b1;
			key_sync_reg <= 1'b1;
			ts_meta_reg  <= 1'b0;
			ts_sync_reg  <= 1'b0;
		end else begin
			scl_meta_reg <= scl_in;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= sda_in;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
			key_meta_reg <= power_key_n_in;
			key_sync_reg <= key_meta_reg;
			ts_meta_reg  <= thermistor_sense_pin_in;
			ts_sync_reg  <= ts_meta_reg;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
	assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
	assign stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

	// ==========================================
	// I2C slave engine
	pmicc_state_t state_reg;
	logic [3:0]   bit_cnt_reg;
	logic [7:0]   shift_reg;
	logic [7:0]   tx_reg;
	logic [7:0]   ptr_reg;
	logic         rw_reg;
	logic         nack_reg;
	logic         sda_oe_reg;
	logic         sda_out_reg;
	logic         wr_stb_reg;
	logic [7:0]   wr_addr_reg;
	logic [7:0]   wr_data_reg;

	// Sampling on SCL rise
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			shift_reg   <= 8'h00;
			nack_reg    <= 1'b1;
		end else if (scl_rise) begin
			if (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_WDATA) begin
				shift_reg <= {shift_reg[6:0], sda_sync_reg};
			end
			if (state_reg == ST_RACK) begin
				nack_reg <= sda_sync_reg;
			end
		end
	end

	// Sequencing, driving on SCL fall so SDA only moves while SCL is low
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			tx_reg      <= 8'h00;
			ptr_reg     <= 8'h00;
			rw_reg      <= 1'b0;
			sda_oe_reg  <= 1'b0;
		end else if (start_det) begin
			state_reg   <= ST_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg  <= 1'b0;
		end else if (stop_det) begin
			state_reg  <= ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (scl_rise && state_reg != ST_IDLE && bit_cnt_reg != 4'h8) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end else if (scl_fall) begin
			case (state_reg)
				ST_ADDR: begin
					if (bit_cnt_reg == 4'h8) begin
						if (shift_reg[7:1] == DEVICE_ADDRESS) begin
							rw_reg     <= shift_reg[0];
							sda_oe_reg <= 1'b1;
							state_reg  <= ST_ADDR_ACK;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					bit_cnt_reg <= 4'h0;
					if (rw_reg) begin
						// Reads start at the stored pointer and auto-increment
						sda_oe_reg <= ~rd_byte[7];
						tx_reg     <= {rd_byte[6:0], 1'b0};
						ptr_reg    <= ptr_reg + 8'h01;
						state_reg  <= ST_RDATA;
					end else begin
						sda_oe_reg <= 1'b0;
						state_reg  <= ST_PTR;
					end
				end
				ST_PTR: begin
					if (bit_cnt_reg == 4'h8) begin
						ptr_reg    <= shift_reg;
						sda_oe_reg <= 1'b1;
						state_reg  <= ST_PTR_ACK;
					end
				end
				ST_WDATA: begin
					if (bit_cnt_reg == 4'h8) begin
						ptr_reg    <= ptr_reg + 8'h01;
						sda_oe_reg <= 1'b1;
						state_reg  <= ST_WDATA_ACK;
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK: begin
					bit_cnt_reg <= 4'h0;
					sda_oe_reg  <= 1'b0;
					state_reg   <= ST_WDATA;
				end
				ST_RDATA: begin
					if (bit_cnt_reg == 4'h8) begin
						sda_oe_reg <= 1'b0;
						state_reg  <= ST_RACK;
					end else begin
						sda_oe_reg <= ~tx_reg[7];
						tx_reg     <= {tx_reg[6:0], 1'b0};
					end
				end
				ST_RACK: begin
					bit_cnt_reg <= 4'h0;
					if (nack_reg) begin
						state_reg <= ST_IDLE;
					end else begin
						sda_oe_reg <= ~rd_byte[7];
						tx_reg     <= {rd_byte[6:0], 1'b0};
						ptr_reg    <= ptr_reg + 8'h01;
						state_reg  <= ST_RDATA;
					end
				end
				default: begin
					state_reg  <= ST_IDLE;
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: the data level is always low, only the enable moves
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
		end
	end

	// One-cycle write strobe when a data byte completes
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_stb_reg  <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_stb_reg <= scl_fall && !start_det && !stop_det
				&& state_reg == ST_WDATA && bit_cnt_reg == 4'h8;
			wr_addr_reg <= ptr_reg;
			wr_data_reg <= shift_reg;
		end
	end

	// ==========================================
	// Register writes
	logic unlocked;
	assign unlocked = (charger_write_key_reg == KEY_UNLOCK);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			power_key_long_press_time_reg <= LONG_PRESS_RST;
		end else if (wr_stb_reg && wr_addr_reg == ADDR_POWER_KEY) begin
			power_key_long_press_time_reg <= wr_data_reg[1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			charger_write_key_reg          <= KEY_RST;
			thermistor_control_enable_reg  <= THERM_RST;
			charge_safety_timer_enable_reg <= TIMER_RST;
			charger_enable_reg             <= CHARGER_ENABLE_RST;
		end else if (wr_stb_reg && wr_addr_reg == ADDR_CHG_CTL) begin
			charger_write_key_reg          <= wr_data_reg[KEY_LSB +: 5];
			thermistor_control_enable_reg  <= wr_data_reg[THERM_BIT];
			charge_safety_timer_enable_reg <= wr_data_reg[TIMER_BIT];
			charger_enable_reg             <= wr_data_reg[CHARGER_ENABLE_BIT];
		end
	end

	// Key is judged before this write lands, so a relock takes one write
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fast_charge_current_code_reg <= FCC_RST;
		end else if (wr_stb_reg && wr_addr_reg == ADDR_FCC && unlocked) begin
			fast_charge_current_code_reg <= wr_data_reg[5:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fast_charge_current_ma_reg <= 9'(FCC_RST) * 9'(CURRENT_STEP_MA);
		end else begin
			// Widen before the product, a 6-bit product would wrap above 63 mA
			fast_charge_current_ma_reg <= 9'(fast_charge_current_code_reg) * 9'(CURRENT_STEP_MA);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			watchdog_kick_reg <= 1'b0;
		end else begin
			watchdog_kick_reg <= wr_stb_reg && wr_addr_reg == ADDR_WD_KICK
				&& wr_data_reg[2:0] == KICK_CODE;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			thermistor_sense_active_out <= 1'b0;
		end else begin
			thermistor_sense_active_out <= thermistor_control_enable_reg & ts_sync_reg;
		end
	end

	// ==========================================
	// Power key long press timing
	logic [31:0] sec_tick_reg;
	logic [4:0]  sec_cnt_reg;
	logic        press_done_reg;
	logic        long_press_reg;
	logic [4:0]  press_target;
	assign press_target = 5'(({3'h0, power_key_long_press_time_reg} + 5'h01) * LONG_PRESS_STEP_S);

	always_ff @(posedge clk_in) begin
		if (reset_in || key_sync_reg) begin
			sec_tick_reg   <= 32'h0;
			sec_cnt_reg    <= 5'h00;
			press_done_reg <= 1'b0;
			long_press_reg <= 1'b0;
		end else begin
			long_press_reg <= 1'b0;
			if (sec_tick_reg == 32'(KEY_SECOND_CYCLES - 1)) begin
				sec_tick_reg <= 32'h0;
				sec_cnt_reg  <= sec_cnt_reg + 5'h01;
			end else begin
				sec_tick_reg <= sec_tick_reg + 32'h1;
			end
			// One pulse per press, however long it is held
			if (!press_done_reg && sec_cnt_reg == press_target) begin
				press_done_reg <= 1'b1;
				long_press_reg <= 1'b1;
			end
		end
	end

	// ==========================================
	// Watchdog
	logic wd_expired;

	pmicc_watchdog #(
		.PERIOD_CYCLES (WD_CYCLES)
	) u_watchdog (
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.kick_in     (watchdog_kick_reg),
		.expired_out (wd_expired)
	);

	// ==========================================
	// Outputs
	assign sda_out                        = sda_out_reg;
	assign sda_oe_out                     = sda_oe_reg;
	assign charger_enable_out             = charger_enable_reg;
	assign charge_safety_timer_enable_out = charge_safety_timer_enable_reg;
	assign thermistor_control_enable_out  = thermistor_control_enable_reg;
	assign fast_charge_current_code_out   = fast_charge_current_code_reg;
	assign fast_charge_current_ma_out     = fast_charge_current_ma_reg;
	assign power_key_long_press_out       = long_press_reg;
	assign watchdog_expired_out           = wd_expired;

endmodule

// *** testbench/pmicc_top_monitor.sv ***
// Concurrent checks on the ports of the charger control register block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module pmicc_top_monitor #(
	parameter int KEY_SECOND_CYCLES = 10
) (
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic       sda_oe_out,
	input wire logic       power_key_n_in,
	input wire logic       charger_enable_out,
	input wire logic       charge_safety_timer_enable_out,
	input wire logic       thermistor_control_enable_out,
	input wire logic       thermistor_sense_active_out,
	input wire logic [5:0] fast_charge_current_code_out,
	input wire logic [8:0] fast_charge_current_ma_out,
	input wire logic       power_key_long_press_out,
	input wire logic       watchdog_expired_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	int hold_cnt;

	// ==========================================
	// Key hold length, counted on the raw pin so it never trails the design
	always_ff @(posedge clk_in) begin
		if (reset_in || power_key_n_in) hold_cnt <= 0;
		else hold_cnt <= hold_cnt + 1;
	end

	// ==========================================
	// Port checks; register writes land only while the device drives its acknowledge
	AST_MA_FOLLOWS_CODE: assert property (fast_charge_current_ma_out == 9'($past(fast_charge_current_code_out)) * 9'd5)
		else $error("current in mA does not match code times five");
	AST_SENSE_GATED: assert property (!thermistor_control_enable_out |=> !thermistor_sense_active_out)
		else $error("thermistor sense active while control disabled");
	AST_FCC_WRITE: assert property ($changed(fast_charge_current_code_out) |-> sda_oe_out)
		else $error("current code changed outside a write");
	AST_EN_WRITE: assert property ($changed(charger_enable_out) |-> sda_oe_out)
		else $error("charger enable changed outside a write");
	AST_TMR_WRITE: assert property ($changed(charge_safety_timer_enable_out) |-> sda_oe_out)
		else $error("safety timer enable changed outside a write");
	AST_THERM_WRITE: assert property ($changed(thermistor_control_enable_out) |-> sda_oe_out)
		else $error("thermistor enable changed outside a write");
	AST_WD_KICK: assert property ($fell(watchdog_expired_out) |-> sda_oe_out)
		else $error("watchdog restarted without a kick write");
	AST_PRESS_PULSE: assert property (power_key_long_press_out |=> !power_key_long_press_out)
		else $error("long press pulse wider than one cycle");
	AST_PRESS_HOLD: assert property (power_key_long_press_out |->
		hold_cnt >= 4 * KEY_SECOND_CYCLES && hold_cnt <= 16 * KEY_SECOND_CYCLES + 8)
		else $error("long press pulse outside the 4 to 16 s span");
	cover property ($changed(fast_charge_current_code_out));
	cover property (power_key_long_press_out);
	cover property ($fell(watchdog_expired_out));
endmodule

bind pmicc_top pmicc_top_monitor #(.KEY_SECOND_CYCLES(KEY_SECOND_CYCLES)) pmicc_top_monitor_i (
	.clk_in(clk_in), .reset_in(reset_in), .sda_oe_out(sda_oe_out), .power_key_n_in(power_key_n_in),
	.charger_enable_out(charger_enable_out), .charge_safety_timer_enable_out(charge_safety_timer_enable_out),
	.thermistor_control_enable_out(thermistor_control_enable_out),
	.thermistor_sense_active_out(thermistor_sense_active_out),
	.fast_charge_current_code_out(fast_charge_current_code_out),
	.fast_charge_current_ma_out(fast_charge_current_ma_out),
	.power_key_long_press_out(power_key_long_press_out), .watchdog_expired_out(watchdog_expired_out));

// *** testbench/pmicc_host_model.sv ***
// Host controller on the I2C bus: register write and read frames.
// Assumes an open-drain line resolved outside; a released line reads high.
`timescale 1ns/100ps
module pmicc_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input  wire logic clk_in,
	input  wire logic sda_line_in,
	output logic      scl_out,
	output logic      sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	// ==========================================
	// Bit level: 6 clocks low, 6 high, well above the 4-clock minimum
	task automatic bit_io(input logic b, output logic s);
		scl_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		sda_out <= b;
		repeat (3) @(posedge clk_in);
		scl_out <= 1'b1;
		repeat (6) @(posedge clk_in);
		s = sda_line_in;
	endtask

	task automatic edge_cond(input logic first, input logic second);
		scl_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		sda_out <= first;
		repeat (3) @(posedge clk_in);
		scl_out <= 1'b1;
		repeat (6) @(posedge clk_in);
		sda_out <= second;
		repeat (6) @(posedge clk_in);
	endtask

	task automatic send_byte(input logic [7:0] d, inout logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		nack = nack | s;
	endtask

	// ==========================================
	// Frames: pointer byte first, repeated start before a read
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic nack);
		nack = 1'b0;
		edge_cond(1'b1, 1'b0);
		send_byte({DEV_ADDR, 1'b0}, nack);
		send_byte(ptr, nack);
		send_byte(d, nack);
		edge_cond(1'b0, 1'b1);
	endtask

	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic nack);
		logic s;
		nack = 1'b0;
		edge_cond(1'b1, 1'b0);
		send_byte({DEV_ADDR, 1'b0}, nack);
		send_byte(ptr, nack);
		edge_cond(1'b1, 1'b0);
		send_byte({DEV_ADDR, 1'b1}, nack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(1'b1, s);
		edge_cond(1'b0, 1'b1);
	endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the charger control register block.
// Assumes the host model drives the bus and the line is pulled up.
`timescale 1ns/100ps
module testbench import pmicc_pkg::*;;
	logic       clk, rst, key_n, sense, scl, host_sda, sda_o, sda_oe;
	logic       en, tmr, therm, active, lp, wd;
	logic [5:0] code;
	logic [8:0] ma;
	wire        sda_line = sda_oe ? 1'b0 : host_sda;
	int         errors, compares, cycles;

	pmicc_top #(.KEY_SECOND_CYCLES(10), .WD_CYCLES(50)) pmicc_top_i (
		.clk_in(clk), .reset_in(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
		.sda_oe_out(sda_oe), .power_key_n_in(key_n), .thermistor_sense_pin_in(sense),
		.charger_enable_out(en), .charge_safety_timer_enable_out(tmr),
		.thermistor_control_enable_out(therm), .thermistor_sense_active_out(active),
		.fast_charge_current_code_out(code), .fast_charge_current_ma_out(ma),
		.power_key_long_press_out(lp), .watchdog_expired_out(wd));
	pmicc_host_model #(.DEV_ADDR(DEVICE_ADDRESS)) pmicc_host_model_i (
		.clk_in(clk), .sda_line_in(sda_line), .scl_out(scl), .sda_out(host_sda));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================
	// Shared tasks
	task automatic final_report();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic check_val(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
		logic nack;
		pmicc_host_model_i.write_reg(ptr, d, nack);
		check_val(9'(nack), 9'h000);
	endtask

	task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] d;
		logic       nack;
		pmicc_host_model_i.read_reg(ptr, d, nack);
		check_val({nack, d}, {1'b0, exp});
	endtask

	// ==========================================
	// Scenarios
	task automatic test_reset_values();
		check_val({3'h0, therm, tmr, en, ma[2:0]}, {3'h0, 3'h3, 3'h0});
		check_val(ma, 9'h028);
		reg_rd(8'h10, 8'h03);
		reg_rd(8'h11, 8'h08);
		reg_rd(8'h0c, 8'h01);
		reg_rd(8'h0d, 8'h00);
		reg_rd(8'h20, 8'h00);
	endtask

	task automatic test_write_key();
		reg_wr(8'h11, 8'h3f);
		reg_rd(8'h11, 8'h08);
		reg_wr(8'h10, 8'hab);
		reg_rd(8'h10, 8'hab);
		reg_wr(8'h11, 8'hff);
		reg_rd(8'h11, 8'h3f);
		check_val(ma, 9'h13b);
		reg_wr(8'h10, 8'h03);
		reg_wr(8'h11, 8'h00);
		check_val(9'(code), 9'h03f);
	endtask

	task automatic test_control_bits();
		for (int v = 0; v < 8; v++) begin
			reg_wr(8'h10, 8'(v));
			check_val({6'h00, therm, tmr, en}, 9'(v));
		end
		sense <= 1'b1;
		repeat (4) @(posedge clk);
		check_val(9'(active), 9'h001);
		reg_wr(8'h10, 8'h03);
		check_val(9'(active), 9'h000);
		sense <= 1'b0;
	endtask

	task automatic test_watchdog();
		for (int c = 0; c < 8; c++) begin
			if (c != 1) begin
				repeat (60) @(posedge clk);
				reg_wr(8'h0d, 8'(c));
				check_val(9'(wd), 9'h001);
			end
		end
		reg_wr(8'h0d, 8'h01);
		check_val(9'(wd), 9'h000);
	endtask

	task automatic test_long_press();
		int n;
		for (int c = 0; c < 4; c++) begin
			reg_wr(8'h0c, 8'(c));
			key_n <= 1'b0;
			n = 0;
			while (lp !== 1'b1 && n < 400) begin
				@(posedge clk);
				n++;
			end
			check_val(9'(n >= (c + 1) * 40 && n <= (c + 1) * 40 + 6), 9'h001);
			key_n <= 1'b1;
			repeat (5) @(posedge clk);
		end
	endtask

	// ==========================================
	// Main sequence and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			final_report();
		end
	end

	initial begin
		rst = 1'b1;
		key_n = 1'b1;
		sense = 1'b0;
		errors = 0;
		compares = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		test_reset_values();
		test_write_key();
		test_control_bits();
		test_watchdog();
		test_long_press();
		final_report();
	end
endmodule
